/* File: core/sgl_pkg.sv */
// Constants and types shared by the serial gain word loader.
// Operation
// (R1) Word is shifted in only while the latch line is held low.
// (R2) Each serial clock rising edge shifts the data line into the shift register.
// (R3) Latch rising edge copies the shift register into the active gain word.
// (R4) Top bit of the latched word selects high range (1) or low range (0).
// (R5) Low seven bits form an unsigned gain code, 128 steps per range.
// (R6) Gain code zero in either range turns the transconductance stage off.
// (R7) Linear gain is code times vernier, times range ratio in high range.
// (R8) Power application sets the active word to low range, code zero.
// (R9) Power-up control low powers down but keeps the stored gain word.
// (R10) Only power reapplication, not power-down, returns the word to low range zero.
// (R11) Controller shifts top bit first, exactly eight clock edges per latch-low interval.
package sgl_pkg;

	// Word layout.
	localparam int unsigned WORD_W        = 8;
	localparam int unsigned CODE_W        = 7;
	localparam int unsigned RANGE_BIT     = 7;

	// Gain arithmetic in millionths of a volt per volt.
	localparam int unsigned SCALE_W       = 23;
	localparam int unsigned GAIN_W        = 46;
	localparam logic [SCALE_W-1:0] VERNIER_PPM = 23'h00D9C0;  // 0.055744 V/V.
	localparam logic [SCALE_W-1:0] RATIO_PPM   = 23'h6C0622;  // 7.079458 V/V.
	localparam logic [SCALE_W-1:0] UNITY_PPM   = 23'h0F4240;  // 1.000000 V/V.

	// Serial port minimum timings, in ns, and the system clock period.
	localparam int unsigned SYS_CLK_NS    = 40;
	localparam int unsigned T_PW_NS       = 25;
	localparam int unsigned T_CK_NS       = 50;
	localparam int unsigned T_DS_NS       = 10;
	localparam int unsigned T_ES_NS       = 20;
	localparam int unsigned T_EH_NS       = 10;
	// Least time the latch must stay high so the system side can copy the word.
	localparam int unsigned LATCH_HIGH_CYC = 4;
	localparam int unsigned LATCH_HIGH_NS  = LATCH_HIGH_CYC * SYS_CLK_NS;

	// Active gain word as stored and applied.
	typedef struct packed {
		logic              range_high;
		logic [CODE_W-1:0] gain_step_code;
	} sgl_word_s;

	localparam sgl_word_s WORD_RESET = 8'h00;  // Low range, code zero.

	// Amplifier power state.
	typedef enum logic [0:0] {
		PWR_DOWN   = 1'b0,
		PWR_ACTIVE = 1'b1
	} sgl_pwr_e;

endpackage : sgl_pkg

/* File: core/sgl_shift_in.sv */
// Serial shift register running on the controller's shift clock.
`timescale 1ns/100ps
module sgl_shift_in (
	input  wire logic              serial_shift_clock,
	input  wire logic              rst_n,
	input  wire logic              word_latch_n,
	input  wire logic              serial_data,
	output logic [sgl_pkg::WORD_W-1:0] shift_word
);

	logic [sgl_pkg::WORD_W-1:0] shift_q;
	logic [sgl_pkg::WORD_W-1:0] shift_d;

	// The latch line has a defined setup and hold to this clock, so it is
	// sampled directly; a synchroniser here would lose the first bits.
	always_comb begin
		shift_d = shift_q;
		if (!word_latch_n) begin
			shift_d = {shift_q[sgl_pkg::WORD_W-2:0], serial_data};  // [R1] [R2]
		end
	end

	// Register the shift chain; the oldest bit ends up on top.
	always_ff @(posedge serial_shift_clock or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= '0;
		end else begin
			shift_q <= shift_d;
		end
	end

	assign shift_word = shift_q;

endmodule : sgl_shift_in

/* File: core/sgl_gain_calc.sv */
// Linear gain calculation from the applied gain word.
`timescale 1ns/100ps
module sgl_gain_calc (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire sgl_pkg::sgl_word_s    word,
	output logic [sgl_pkg::GAIN_W-1:0] gain_pico
);

	logic [sgl_pkg::SCALE_W-1:0] code_ppm;
	logic [sgl_pkg::SCALE_W-1:0] range_ppm;
	logic [sgl_pkg::GAIN_W-1:0]  gain_d;
	logic [sgl_pkg::GAIN_W-1:0]  gain_q;

	// Gain in 1e-12 V/V: code times vernier, times the range ratio or unity.
	always_comb begin
		code_ppm  = sgl_pkg::SCALE_W'(word.gain_step_code * sgl_pkg::VERNIER_PPM);  // [R5] [R7]
		range_ppm = word.range_high ? sgl_pkg::RATIO_PPM : sgl_pkg::UNITY_PPM;       // [R4] [R7]
		gain_d    = sgl_pkg::GAIN_W'(code_ppm) * sgl_pkg::GAIN_W'(range_ppm);
	end

	// Register the result so the output comes from a flip-flop.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_q <= '0;
		end else begin
			gain_q <= gain_d;
		end
	end

	assign gain_pico = gain_q;

endmodule : sgl_gain_calc

/* File: core/sgl_loader.sv */
// Top of the serial gain word loader: capture, latch, power and outputs.
`timescale 1ns/100ps
module sgl_loader (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  serial_shift_clock,
	input  wire logic                  serial_data,
	input  wire logic                  word_latch_n,
	input  wire logic                  power_up_ctl,
	output logic                       range_high,
	output logic [sgl_pkg::CODE_W-1:0] gain_step_code,
	output logic                       gm_stage_on,
	output logic                       amp_powered,
	output logic                       word_loaded,
	output logic [sgl_pkg::GAIN_W-1:0] gain_pico
);

	logic [sgl_pkg::WORD_W-1:0] shift_word;
	logic [2:0]                 latch_sync_q;
	logic [2:0]                 latch_sync_d;
	logic [1:0]                 pwr_sync_q;
	logic [1:0]                 pwr_sync_d;
	logic                       latch_rise;
	sgl_pkg::sgl_word_s         word_q;
	sgl_pkg::sgl_word_s         word_d;
	sgl_pkg::sgl_pwr_e          pwr_q;
	sgl_pkg::sgl_pwr_e          pwr_d;
	logic                       stage_q;
	logic                       stage_d;
	logic                       loaded_q;
	logic                       loaded_d;

	// Shift register in the shift clock domain.
	sgl_shift_in u_shift (
		.serial_shift_clock (serial_shift_clock),
		.rst_n              (rst_n),
		.word_latch_n       (word_latch_n),
		.serial_data        (serial_data),
		.shift_word         (shift_word)
	);

	// Two-flop synchronisers for the latch and power pins; the third latch
	// stage only serves the edge detector, never the first flop.
	always_comb begin
		latch_sync_d = {latch_sync_q[1:0], word_latch_n};
		pwr_sync_d   = {pwr_sync_q[0], power_up_ctl};
		latch_rise   = latch_sync_q[1] & ~latch_sync_q[2];
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_sync_q <= 3'h7;
			pwr_sync_q   <= 2'h0;
		end else begin
			latch_sync_q <= latch_sync_d;
			pwr_sync_q   <= pwr_sync_d;
		end
	end

	// The shift word is stable while the latch is high, since the controller
	// shifts only while it is low; the latch rise thus acts as the handshake.
	always_comb begin
		word_d   = word_q;
		loaded_d = 1'b0;
		if (latch_rise) begin
			word_d   = sgl_pkg::sgl_word_s'(shift_word);  // [R3] [R11]
			loaded_d = 1'b1;
		end
	end

	// Power-down keeps the word; only the power-on reset clears it, and latch rises still load it.
	always_comb begin
		pwr_d   = pwr_sync_q[1] ? sgl_pkg::PWR_ACTIVE : sgl_pkg::PWR_DOWN;  // [R9]
		stage_d = 1'b0;
		case (pwr_d)
			sgl_pkg::PWR_ACTIVE: begin
				stage_d = (word_d.gain_step_code != '0);  // [R6]
			end
			sgl_pkg::PWR_DOWN: begin
				stage_d = 1'b0;
			end
			default: begin
				stage_d = 1'b0;
			end
		endcase
	end

	// The reset stands for power application; nothing else clears the word.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_q   <= sgl_pkg::WORD_RESET;  // [R8] [R10]
			pwr_q    <= sgl_pkg::PWR_DOWN;
			stage_q  <= 1'b0;
			loaded_q <= 1'b0;
		end else begin
			word_q   <= word_d;
			pwr_q    <= pwr_d;
			stage_q  <= stage_d;
			loaded_q <= loaded_d;
		end
	end

	// Linear gain from the applied word.
	sgl_gain_calc u_gain (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.word      (word_q),
		.gain_pico (gain_pico)
	);

	// Outputs, all from flip-flops.
	assign range_high     = word_q.range_high;      // [R4]
	assign gain_step_code = word_q.gain_step_code;  // [R5]
	assign gm_stage_on    = stage_q;
	assign amp_powered    = (pwr_q == sgl_pkg::PWR_ACTIVE);
	assign word_loaded    = loaded_q;

endmodule : sgl_loader

/* File: testbench/sgl_checker.sv */
// Port-level assertions for the gain word loader.
`timescale 1ns/100ps
module sgl_checker (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        word_latch_n,
	input wire logic        power_up_ctl,
	input wire logic        range_high,
	input wire logic [6:0]  gain_step_code,
	input wire logic        gm_stage_on,
	input wire logic        amp_powered,
	input wire logic        word_loaded,
	input wire logic [45:0] gain_pico
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Power pin held steady over three samples.
	sequence s_up; power_up_ctl [*3]; endsequence
	sequence s_down; (!power_up_ctl) [*3]; endsequence
	// Word, power and gain relations on every system edge.
	a_word_hold: assert property (!$stable({range_high, gain_step_code}) |-> word_loaded)
		else $error("word moved without load");
	a_latch_load: assert property ($rose(word_latch_n) |-> ##[1:5] word_loaded)
		else $error("latch rise not loaded");
	a_load_pulse: assert property (word_loaded |=> !word_loaded)
		else $error("load pulse too long");
	a_stage_on: assert property (gm_stage_on == (amp_powered && gain_step_code != 7'h00))
		else $error("stage enable wrong");
	a_gain_value: assert property (gain_pico == $past(gain_step_code) * 46'h00D9C0 *
		($past(range_high) ? 46'h6C0622 : 46'h0F4240)) else $error("gain wrong");
	a_power_on: assert property (s_up |=> amp_powered)
		else $error("not powered");
	a_power_off: assert property (s_down |=> !amp_powered && !gm_stage_on)
		else $error("not powered down");
	a_reset_word: assert property (disable iff (1'b0) !rst_n |-> {range_high, gain_step_code} == 8'h00)
		else $error("reset word wrong");
endmodule : sgl_checker

bind sgl_loader sgl_checker u_chk (.sys_clk, .rst_n, .word_latch_n, .power_up_ctl,
	.range_high, .gain_step_code, .gm_stage_on, .amp_powered, .word_loaded, .gain_pico);

/* File: testbench/sgl_ctl_model.sv */
// Controller model that shifts gain words into the loader.
`timescale 1ns/100ps
module sgl_ctl_model (
	output logic serial_shift_clock,
	output logic serial_data,
	output logic word_latch_n
);
	// Idle: clock stands low, latch high.
	initial begin
		serial_shift_clock = 1'b0;
		serial_data = 1'b0;
		word_latch_n = 1'b1;
	end
	// Sends one word top bit first; slow stretches the low phase.
	task automatic send(input logic [7:0] w, input int slow);
		#3.7 word_latch_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			serial_data = w[i];
			#(6 + slow) serial_shift_clock = 1'b1;
			#6 serial_shift_clock = 1'b0;
		end
		#20 word_latch_n = 1'b1;
		serial_data = ~serial_data;
	endtask : send
endmodule : sgl_ctl_model

/* File: testbench/serial_gain_word_loader_bench.sv */
// Self-checking bench for the serial gain word loader.
`timescale 1ns/100ps
module serial_gain_word_loader_bench;
	logic sys_clk, rst_n, power_up_ctl, serial_shift_clock, serial_data, word_latch_n;
	logic range_high, gm_stage_on, amp_powered, word_loaded;
	logic [6:0] gain_step_code;
	logic [45:0] gain_pico;
	int seed, checks, n_mismatch;
	sgl_loader dut (.*);
	sgl_ctl_model ctl (.*);
	// System clock, 40 ns.
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Compares one value and counts it.
	task automatic check(input logic [45:0] seen, input logic [45:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Prints the counts and the verdict, then stops.
	task automatic results;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	// Expected gain in millionths times millionths.
	function automatic logic [45:0] gain_of(input logic [7:0] w);
		return w[6:0] * 46'h00D9C0 * (w[7] ? 46'h6C0622 : 46'h0F4240);
	endfunction : gain_of
	// Shifts one word, waits for the load and checks the outputs.
	task automatic load(input logic [7:0] w);
		int n;
		n = 0;
		ctl.send(w, w[0] ? 9 : 0);
		while (word_loaded !== 1'b1) begin
			@(negedge sys_clk);
			n++;
			if (n > 20) begin
				n_mismatch++;
				results();
			end
		end
		check(range_high, w[7]);
		check(gain_step_code, w[6:0]);
		check(gm_stage_on, power_up_ctl && w[6:0] != 7'h00);
		@(negedge sys_clk);
		check(gain_pico, gain_of(w));
		repeat (3) @(negedge sys_clk);
	endtask : load
	// Main sequence: words, power-down, second reset.
	initial begin
		seed = 15544;
		checks = 0;
		n_mismatch = 0;
		rst_n = 1'b0;
		power_up_ctl = 1'b1;
		repeat (20) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		@(negedge sys_clk);
		check({range_high, gain_step_code}, 8'h00);
		for (int i = 0; i < 12; i++)
			load(i == 0 ? 8'h80 : i == 1 ? 8'hFF : i == 2 ? 8'h01 : 8'($random(seed)));
		$display("word test done");
		@(posedge sys_clk);
		#1 power_up_ctl = 1'b0;
		repeat (6) @(negedge sys_clk);
		check(amp_powered, 1'b0);
		load(8'hAD);
		@(posedge sys_clk);
		#1 power_up_ctl = 1'b1;
		repeat (6) @(negedge sys_clk);
		check({amp_powered, gm_stage_on, range_high, gain_step_code}, 10'h3AD);
		$display("power test done");
		@(posedge sys_clk);
		#1 rst_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		@(negedge sys_clk);
		check({range_high, gain_step_code}, 8'h00);
		$display("reset test done");
		results();
	end
endmodule : serial_gain_word_loader_bench
